// *** rtl/mwsd_sequencer.sv ***
// Decode and next-address sequencer for one control-store microword per clock.
`timescale 1ns/1ps

// Functional notes
// - B-select code 2 puts constant on B
// - High code 8 plus module-set loads constant bits 0-4
// - Address parity makes module+word odd
// - Address is module digit then word digits
// - Module switch fetches from new module
// - Status statement changes one status bit only
// - High/low tests set word bits 1/0
// - Bits 1/0 forced 0, 1, or tested
// - Next-address bit 0 also feeds aux data
// - ALU function field picks one of eight
// - Low code 6 loads A bus for 256-way branch
module mwsd_sequencer
  import mwsd_pkg::*;
(
  input  wire logic          ref_clk_in,
  input  wire logic          rst_in,
  input  wire mwsd_word_type word_in,
  input  wire logic [7:0]    a_bus_in,
  input  wire logic [7:0]    byte_reg_in,
  input  wire logic [7:0]    data_reg_in,
  input  wire logic [7:0]    op_reg_in,
  input  wire logic [7:0]    tag_lines_in,
  input  wire logic          index_in,
  input  wire logic [1:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire logic          reg_write_in,
  input  wire logic          reg_read_in,
  output mwsd_addr_type      fetch_addr_out,
  output logic [7:0]         b_bus_out,
  output logic [7:0]         d_bus_out,
  output logic [7:0]         status_bits_out,
  output logic               aux_data_bit_out,
  output logic [7:0]         reg_rdata_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] tag_s1_q, tag_s2_q, tag_s3_q, tag_q, tag_d;
  logic       idx_s1_q, idx_s2_q, idx_s3_q, idx_q, idx_d;

  // A tag or index change is accepted only once stages two and three agree.
  always_comb begin
    tag_d = tag_q;
    idx_d = idx_q;
    for (int i = 0; i < 8; i++) begin
      if (tag_s2_q[i] == tag_s3_q[i]) begin
        tag_d[i] = tag_s3_q[i];
      end
    end
    if (idx_s2_q == idx_s3_q) begin
      idx_d = idx_s3_q;
    end
  end

  // Synchroniser chain; the first stage feeds only the second.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tag_s1_q <= 8'h00;
      tag_s2_q <= 8'h00;
      tag_s3_q <= 8'h00;
      tag_q    <= 8'h00;
      idx_s1_q <= 1'h0;
      idx_s2_q <= 1'h0;
      idx_s3_q <= 1'h0;
      idx_q    <= 1'h0;
    end else begin
      tag_s1_q <= tag_lines_in;
      tag_s2_q <= tag_s1_q;
      tag_s3_q <= tag_s2_q;
      tag_q    <= tag_d;
      idx_s1_q <= index_in;
      idx_s2_q <= idx_s1_q;
      idx_s3_q <= idx_s2_q;
      idx_q    <= idx_d;
    end
  end

  // ****************************************
  // B bus and ALU
  // ****************************************
  logic [7:0] b_bus, b_oper, alu_res;
  logic [8:0] sum;
  logic       cin, carry_op;

  // B source select; the constant field reaches the ALU only on code 2.
  always_comb begin
    unique case (word_in.b_bus_source_select)
      MWSD_CB_ZERO:  b_bus = 8'h00;
      MWSD_CB_BYTE:  b_bus = byte_reg_in;
      MWSD_CB_CONST: b_bus = word_in.constant_field;
      MWSD_CB_DATA:  b_bus = data_reg_in;
    endcase
  end

  logic [7:0] st_q, st_d;
  logic       co_q, co_d, dz_q, dz_d;

  // Eight functions; subtraction is the complemented B path with carry-in.
  always_comb begin
    b_oper   = word_in.b_complement ? ~b_bus : b_bus;
    cin      = 1'h0;
    carry_op = 1'h0;
    unique case (word_in.alu_function_field)
      MWSD_CC_ADD:   cin = 1'h0;
      MWSD_CC_ADDC:  cin = 1'h1;
      MWSD_CC_ADDK:  carry_op = 1'h1;
      MWSD_CC_ADDCK: begin
        cin      = 1'h1;
        carry_op = 1'h1;
      end
      MWSD_CC_ADDSK: begin
        cin      = st_q[MWSD_ST_CARRY];
        carry_op = 1'h1;
      end
      default:       cin = 1'h0;
    endcase
    sum = {1'h0, a_bus_in} + {1'h0, b_oper} + {8'h00, cin};
    unique case (word_in.alu_function_field)
      MWSD_CC_AND: alu_res = a_bus_in & b_oper;
      MWSD_CC_OR:  alu_res = a_bus_in | b_oper;
      MWSD_CC_XOR: alu_res = a_bus_in ^ b_oper;
      default:     alu_res = sum[7:0];
    endcase
  end

  // ****************************************
  // Status register and condition latches
  // ****************************************
  logic [7:0] ctrl_q, ctrl_d;
  logic       run;
  logic [3:0] cs;

  assign run = ctrl_q[MWSD_CTRL_RUN];
  assign cs  = word_in.status_field;

  // Carry capture comes first so that an explicit status statement wins on bit 3.
  always_comb begin
    st_d = st_q;
    co_d = co_q;
    dz_d = dz_q;
    if (run) begin
      dz_d = (alu_res == 8'h00);
      if (word_in.alu_function_field != MWSD_CC_AND &&
          word_in.alu_function_field != MWSD_CC_OR &&
          word_in.alu_function_field != MWSD_CC_XOR) begin
        co_d = sum[8];
      end
      if (carry_op) begin
        st_d[MWSD_ST_CARRY] = sum[8];
      end
      unique case (cs)
        4'h1: st_d[0] = 1'h0;
        4'h2: st_d[0] = 1'h1;
        4'h3: st_d[1] = 1'h0;
        4'h4: st_d[1] = 1'h1;
        4'h5: st_d[2] = 1'h0;
        MWSD_CS_DNZ: st_d[MWSD_ST_DNZ] = st_q[MWSD_ST_DNZ] | (alu_res != 8'h00);
        4'h7: st_d[3] = 1'h0;
        4'h8: st_d[3] = 1'h1;
        4'h9: st_d[4] = 1'h0;
        4'hA: st_d[5] = 1'h0;
        4'hB: st_d[5] = 1'h1;
        4'hC: st_d[6] = 1'h0;
        4'hD: st_d[6] = 1'h1;
        4'hE: st_d[7] = 1'h0;
        4'hF: st_d[7] = 1'h1;
        default: st_d = st_d;
      endcase
    end
  end

  // ****************************************
  // Branch tests and next address
  // ****************************************
  logic       hi_bit, lo_bit;
  logic [4:0] w_q, w_d;
  logic [7:0] x_q, x_d;
  logic       aux_q, aux_d;

  // High test drives word bit 1; codes 0, 1 and 8 force the bit.
  always_comb begin
    unique case (word_in.high_branch_test)
      4'h0:    hi_bit = 1'h0;
      4'h1:    hi_bit = 1'h1;
      4'h2:    hi_bit = st_q[0];
      4'h3:    hi_bit = op_reg_in[1];
      4'h4:    hi_bit = st_q[2];
      4'h5:    hi_bit = st_q[4];
      4'h6:    hi_bit = st_q[6];
      4'h7:    hi_bit = tag_q[7];
      4'h8:    hi_bit = 1'h0;
      4'h9:    hi_bit = co_q;
      4'hA:    hi_bit = tag_q[2];
      4'hB:    hi_bit = tag_q[4];
      4'hC:    hi_bit = tag_q[6];
      4'hD:    hi_bit = op_reg_in[7];
      4'hE:    hi_bit = op_reg_in[5];
      4'hF:    hi_bit = op_reg_in[3];
    endcase
  end

  // Low test drives word bit 0; index only counts once status bit 1 allows it.
  always_comb begin
    unique case (word_in.low_branch_test)
      4'h0:    lo_bit = 1'h0;
      4'h1:    lo_bit = 1'h1;
      4'h2:    lo_bit = st_q[3];
      4'h3:    lo_bit = st_q[5];
      4'h4:    lo_bit = st_q[7];
      4'h5:    lo_bit = dz_q;
      4'h8:    lo_bit = tag_q[1];
      4'h9:    lo_bit = tag_q[3];
      4'hA:    lo_bit = tag_q[5];
      4'hB:    lo_bit = op_reg_in[6];
      4'hC:    lo_bit = op_reg_in[4];
      4'hD:    lo_bit = op_reg_in[2];
      4'hE:    lo_bit = idx_q & st_q[MWSD_ST_INDEX];
      4'hF:    lo_bit = op_reg_in[0];
      default: lo_bit = 1'h0;
    endcase
  end

  // While run is set, word select takes the next-address field and both test results, or the A bus on low code 6.
  always_comb begin
    w_d   = w_q;
    x_d   = x_q;
    aux_d = aux_q;
    if (run) begin
      x_d   = {word_in.next_address_field, hi_bit, lo_bit};
      aux_d = word_in.next_address_field[0];
      if (word_in.low_branch_test == MWSD_CL_ABUS) begin
        x_d = a_bus_in;
      end
      if (word_in.high_branch_test == MWSD_CH_MODSET && word_in.module_set) begin
        w_d = word_in.constant_field[4:0];
      end
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  logic [7:0] rdata_d, rdata_q;

  // Control writes steer the run bit; reads show status and the fetch address.
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 8'h00;
    if (reg_write_in && reg_addr_in == MWSD_REG_CTRL) begin
      ctrl_d = reg_wdata_in;
    end
    if (reg_read_in) begin
      unique case (reg_addr_in)
        MWSD_REG_CTRL:   rdata_d = ctrl_q;
        MWSD_REG_STATUS: rdata_d = st_q;
        MWSD_REG_ADDR:   rdata_d = x_q;
        default:         rdata_d = {2'h0, fetch_addr_out.address_parity_bit, w_q};
      endcase
    end
  end

  // All state except the pin synchronisers; the parity flop follows the address it covers.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q    <= 8'h00;
      co_q    <= 1'h0;
      dz_q    <= 1'h0;
      w_q     <= MWSD_W_RST;
      x_q     <= MWSD_X_RST;
      aux_q   <= 1'h0;
      ctrl_q  <= MWSD_CTRL_RST;
      rdata_q <= 8'h00;
      fetch_addr_out <= '{1'h1, MWSD_W_RST, MWSD_X_RST};
      b_bus_out <= 8'h00;
      d_bus_out <= 8'h00;
    end else begin
      st_q    <= st_d;
      co_q    <= co_d;
      dz_q    <= dz_d;
      w_q     <= w_d;
      x_q     <= x_d;
      aux_q   <= aux_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      fetch_addr_out <= '{~^{w_d, x_d}, w_d, x_d};
      b_bus_out <= b_bus;
      d_bus_out <= alu_res;
    end
  end

  assign status_bits_out  = st_q;
  assign aux_data_bit_out = aux_q;
  assign reg_rdata_out    = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence modset_s;
    run && word_in.high_branch_test == MWSD_CH_MODSET && word_in.module_set;
  endsequence

  const_on_b_a: assert property (
    word_in.b_bus_source_select == MWSD_CB_CONST |=> b_bus_out == $past(word_in.constant_field))
    else $error("constant not on B bus");
  module_load_a: assert property (
    modset_s |=> w_q == $past(word_in.constant_field[4:0]))
    else $error("module select not loaded");
  addr_parity_a: assert property (
    ^{fetch_addr_out.address_parity_bit, w_q, x_q} == 1'h1)
    else $error("address parity not odd");
  addr_digits_a: assert property (
    fetch_addr_out.module_select == w_q && fetch_addr_out.word_select == x_q)
    else $error("fetch address mismatch");
  module_keep_a: assert property (
    run && !(word_in.high_branch_test == MWSD_CH_MODSET && word_in.module_set) |=> $stable(w_q))
    else $error("module select changed without switch");
  status_one_a: assert property (
    run && cs == 4'hB && !carry_op |=> st_q[5] && (st_q & 8'hDF) == ($past(st_q) & 8'hDF))
    else $error("status statement disturbed other bits");
  high_force_a: assert property (
    run && word_in.high_branch_test == 4'h1 && word_in.low_branch_test == 4'h0
    |=> x_q[1:0] == 2'h2)
    else $error("forced branch bits wrong");
  low_test_a: assert property (
    run && word_in.low_branch_test == 4'h5 |=> x_q[0] == $past(dz_q))
    else $error("low branch test wrong");
  aux_bit_a: assert property (
    run |=> aux_data_bit_out == $past(word_in.next_address_field[0]))
    else $error("aux data bit wrong");
  xor_func_a: assert property (
    word_in.alu_function_field == MWSD_CC_XOR
    |=> d_bus_out == ($past(a_bus_in) ^ ($past(word_in.b_complement) ? ~b_bus_out : b_bus_out)))
    else $error("exclusive or wrong");
  wide_branch_a: assert property (
    run && word_in.low_branch_test == MWSD_CL_ABUS |=> x_q == $past(a_bus_in))
    else $error("A bus branch not taken");
  hold_stop_a: assert property (
    !run ##1 !run |-> $stable(fetch_addr_out))
    else $error("address moved while stopped");

endmodule

// *** rtl/mwsd_pkg.sv ***
// Package with constants and carrier types for the microword sequencer decode block.
package mwsd_pkg;

  // ****************************************
  // Microword field codes
  // ****************************************
  localparam logic [1:0] MWSD_CB_ZERO   = 2'h0;
  localparam logic [1:0] MWSD_CB_BYTE   = 2'h1;
  localparam logic [1:0] MWSD_CB_CONST  = 2'h2;
  localparam logic [1:0] MWSD_CB_DATA   = 2'h3;
  localparam logic [2:0] MWSD_CC_ADD    = 3'h0;
  localparam logic [2:0] MWSD_CC_ADDC   = 3'h1;
  localparam logic [2:0] MWSD_CC_AND    = 3'h2;
  localparam logic [2:0] MWSD_CC_OR     = 3'h3;
  localparam logic [2:0] MWSD_CC_ADDK   = 3'h4;
  localparam logic [2:0] MWSD_CC_ADDCK  = 3'h5;
  localparam logic [2:0] MWSD_CC_ADDSK  = 3'h6;
  localparam logic [2:0] MWSD_CC_XOR    = 3'h7;
  localparam logic [3:0] MWSD_CH_MODSET = 4'h8;
  localparam logic [3:0] MWSD_CL_ABUS   = 4'h6;
  localparam logic [3:0] MWSD_CS_DNZ    = 4'h6;
  localparam int         MWSD_ST_CARRY  = 3;
  localparam int         MWSD_ST_DNZ    = 2;
  localparam int         MWSD_ST_INDEX  = 1;

  // ****************************************
  // Register port map and reset values
  // ****************************************
  localparam logic [1:0] MWSD_REG_CTRL   = 2'h0;
  localparam logic [1:0] MWSD_REG_STATUS = 2'h1;
  localparam logic [1:0] MWSD_REG_ADDR   = 2'h2;
  localparam int         MWSD_CTRL_RUN   = 0;
  localparam logic [7:0] MWSD_CTRL_RST   = 8'h01;
  localparam logic [4:0] MWSD_W_RST      = 5'h00;
  localparam logic [7:0] MWSD_X_RST      = 8'h00;

  // One control-store word as it arrives from the read-only store.
  typedef struct packed {
    logic [5:0] next_address_field;
    logic [2:0] alu_function_field;
    logic       b_complement;
    logic [3:0] status_field;
    logic [3:0] high_branch_test;
    logic [3:0] low_branch_test;
    logic [1:0] b_bus_source_select;
    logic [7:0] constant_field;
    logic       module_set;
  } mwsd_word_type;

  // Fetch address with its parity bit.
  typedef struct packed {
    logic       address_parity_bit;
    logic [4:0] module_select;
    logic [7:0] word_select;
  } mwsd_addr_type;

endpackage

// *** bench/mwsd_control_store.sv ***
// Read-only control-store model that answers the sequencer's fetch address.
`timescale 1ns/1ps

module mwsd_control_store
  import mwsd_pkg::*;
(
  input  wire mwsd_addr_type addr_in,
  output mwsd_word_type      word_out,
  output logic               parity_err_out
);
  // ****************************************
  // Store array and flow-through read
  // ****************************************
  mwsd_word_type mem [0:8191];

  // Unprogrammed words read as all-zero no-op words, never as unknowns.
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = '0;
    end
  end

  // The store answers in the same cycle, so a stale word would show as a wrong address.
  assign word_out       = mem[{addr_in.module_select, addr_in.word_select}];
  assign parity_err_out = ~(^addr_in);
endmodule

// *** bench/mwsd_sequencer_tb.sv ***
// Self-checking testbench for the microword sequencer decode block.
`timescale 1ns/1ps

module mwsd_sequencer_tb
  import mwsd_pkg::*;
  ;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic          ref_clk_in = 1'b0;
  logic          rst_in     = 1'b1;
  mwsd_word_type word;
  mwsd_addr_type fetch_addr;
  logic [7:0]    a_bus, reg_wdata, b_bus, d_bus, status, rdata, op_reg;
  logic [1:0]    reg_addr;
  logic          reg_write, reg_read, aux, perr;
  int            failures, num_checks, cycles;
  logic [7:0]    dexp [0:7] = '{8'h10, 8'h11, 8'h20, 8'hF0, 8'h10, 8'h11, 8'h11, 8'hD0};

  // Free-running clock of 8 ns.
  always #4 ref_clk_in = ~ref_clk_in;

  mwsd_sequencer i_mwsd_sequencer (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .word_in(word), .a_bus_in(a_bus),
    .byte_reg_in(8'h3C), .data_reg_in(8'hC3), .op_reg_in(op_reg), .tag_lines_in(8'h00),
    .index_in(1'h0), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_write_in(reg_write), .reg_read_in(reg_read), .fetch_addr_out(fetch_addr),
    .b_bus_out(b_bus), .d_bus_out(d_bus), .status_bits_out(status),
    .aux_data_bit_out(aux), .reg_rdata_out(rdata));

  mwsd_control_store i_mwsd_control_store (
    .addr_in(fetch_addr), .word_out(word), .parity_err_out(perr));

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic mwsd_word_type mkw(input logic [5:0] cn, input logic [2:0] cc,
    input logic [3:0] cs, ch, cl, input logic [1:0] cb, input logic [7:0] k, input logic ms);
    return {cn, cc, 1'b0, cs, ch, cl, cb, k, ms};
  endfunction

  task automatic put(input logic [4:0] m, input logic [7:0] w, input mwsd_word_type mw);
    i_mwsd_control_store.mem[{m, w}] = mw;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Odd parity over parity bit, module and word means the bit is the inverted XOR.
  task automatic chk_addr(input logic [4:0] m, input logic [7:0] w);
    mwsd_addr_type e;
    e = {~^{m, w}, m, w};
    num_checks++;
    if (fetch_addr !== e) begin
      failures++;
      $display("MISMATCH at %0t: address got %h expected %h", $time, fetch_addr, e);
    end
    chk8({7'h00, perr}, 8'h00, "store parity flag");
  endtask

  // One microcycle: results of the word just taken are checked once they settle.
  task automatic step(input logic [4:0] m, input logic [7:0] w, b, d, s);
    @(posedge ref_clk_in);
    #1;
    chk_addr(m, w);
    chk8(b_bus, b, "b bus");
    chk8(d_bus, d, "d bus");
    chk8(status, s, "status");
  endtask

  // Register port: strobes last one cycle, read data stand only in the next cycle.
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk_in);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge ref_clk_in);
    reg_read <= 1'h0;
    #1;
    chk8(rdata, v, "read data");
    // Read data must not linger once the strobe has gone.
    @(posedge ref_clk_in);
    #1;
    chk8(rdata, 8'h00, "read data idle");
  endtask

  // Hang guard: the whole run needs well under a hundred cycles.
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    a_bus     = 8'hF0;
    op_reg    = 8'h00;
    reg_addr  = 2'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    failures  = 0;
    num_checks = 0;
    cycles    = 0;
    #1;
    put(5'h00, 8'h00, mkw(6'h3F, MWSD_CC_ADD, 4'h0, 4'h1, 4'h0, MWSD_CB_CONST, 8'h5A, 1'b0));
    put(5'h00, 8'hFE, mkw(6'h00, MWSD_CC_XOR, 4'hB, MWSD_CH_MODSET, 4'h1, MWSD_CB_CONST,
                          8'h05, 1'b1));
    for (int i = 0; i < 8; i++) begin
      put(5'h05, (i == 0) ? 8'h01 : 8'(4 * i),
          mkw(6'(i + 1), 3'(i), 4'h0, 4'h0, 4'h5, MWSD_CB_CONST, 8'h20, 1'h0));
    end
    put(5'h05, 8'h20, mkw(6'h09, MWSD_CC_ADD, 4'hF, 4'h2, 4'h3, MWSD_CB_ZERO, 8'h00, 1'b0));
    put(5'h05, 8'h25, mkw(6'h00, MWSD_CC_ADD, 4'hA, 4'h0, MWSD_CL_ABUS, MWSD_CB_ZERO,
                          8'h00, 1'b0));
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
    chk_addr(5'h00, 8'h00);
    $display("test reset done");
    step(5'h00, 8'hFE, 8'h5A, 8'h4A, 8'h00);
    chk8({7'h00, aux}, 8'h01, "aux data bit");
    step(5'h05, 8'h01, 8'h05, 8'hF5, 8'h20);
    chk8({7'h00, aux}, 8'h00, "aux data bit");
    for (int i = 0; i < 8; i++) begin
      step(5'h05, 8'(4 * (i + 1)), 8'h20, dexp[i], (i < 4) ? 8'h20 : 8'h28);
    end
    $display("test alu functions done");
    step(5'h05, 8'h25, 8'h00, 8'hF0, 8'hA8);
    step(5'h05, 8'hF0, 8'h00, 8'hF0, 8'h88);
    step(5'h05, 8'h00, 8'h00, 8'hF0, 8'h88);
    $display("test branching done");
    rd(MWSD_REG_STATUS, 8'h88);
    rd(MWSD_REG_ADDR, 8'h00);
    rd(2'h3, {2'h0, ~^{5'h05, 8'h00}, 5'h05});
    rd(MWSD_REG_CTRL, MWSD_CTRL_RST);
    wr(MWSD_REG_ADDR, 8'h77);
    rd(MWSD_REG_ADDR, 8'h00);
    $display("test registers done");
    // With run cleared the address must hold even though the word now branches away.
    wr(MWSD_REG_CTRL, 8'h00);
    op_reg <= 8'h80;
    // The store word changes only after the stopping edge, so that edge sees the old word.
    #1;
    put(5'h05, 8'h00, mkw(6'h3F, MWSD_CC_ADD, 4'h0, 4'hD, 4'hF, MWSD_CB_ZERO, 8'h00, 1'h0));
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk_addr(5'h05, 8'h00);
    wr(MWSD_REG_CTRL, MWSD_CTRL_RST);
    // Operand bits count from the top: the high test sees bit 7 set, the low test bit 0 clear.
    step(5'h05, 8'hFE, 8'h00, 8'hF0, 8'h88);
    step(5'h05, 8'h00, 8'h00, 8'hF0, 8'h88);
    $display("test run control done");
    complete_run();
  end
endmodule
